// ===== design/efcc_pkg.sv
// constants and types shared by the flash command controller
// assumes a 32-bit APB slave of two controllers on one pclk
//==================================================
package efcc_pkg;
  //==================================================
  // register map
  localparam logic [7:0] MODE0_OFF = 8'h60;
  localparam logic [7:0] CMD0_OFF  = 8'h64;
  localparam logic [7:0] STAT0_OFF = 8'h68;
  localparam logic [7:0] MODE1_OFF = 8'h70;
  localparam logic [7:0] CMD1_OFF  = 8'h74;
  localparam logic [7:0] STAT1_OFF = 8'h78;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [7:0] CMD_KEY = 8'h5A;
  //==================================================
  // status bit positions
  localparam int READY_BIT  = 0;
  localparam int LOCK_ERROR_FLAG_BIT  = 2;
  localparam int COMMAND_ERROR_FLAG_BIT  = 3;
  localparam int SECUR_BIT  = 4;
  localparam int NV_LSB     = 8;
  localparam int LOCKS_LSB  = 16;
  //==================================================
  // command codes
  typedef enum logic [3:0] {
    EFCC_NOP   = 4'h0,
    EFCC_WP    = 4'h1,
    EFCC_SLB   = 4'h2,
    EFCC_WPL   = 4'h3,
    EFCC_CLB   = 4'h4,
    EFCC_EA    = 4'h8,
    EFCC_SET_NV_BIT_CMD  = 4'hB,
    EFCC_CLEAR_NV_BIT_CMD  = 4'hD,
    EFCC_SSB   = 4'hF
  } efcc_code_e;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ERASE = 3'b001,
    ST_PROG  = 3'b010,
    ST_NVOP  = 3'b011,
    ST_EALL  = 3'b100
  } efcc_state_e;
  typedef struct packed {
    logic [7:0] rsvd_hi;
    logic [7:0] microsecond_cycles;
    logic [5:0] rsvd_mid;
    logic [1:0] wait_state_count;
    logic       skip_erase;
    logic [2:0] rsvd_lo;
    logic       cmd_err_ie;
    logic       lock_err_ie;
    logic       rsvd_b1;
    logic       ready_ie;
  } efcc_mode_s;
  typedef struct packed {
    logic [7:0] key;
    logic [5:0] rsvd_hi;
    logic [9:0] page_number;
    logic [3:0] rsvd_lo;
    logic [3:0] command_code;
  } efcc_cmd_s;
  localparam logic [31:0] MODE_WMASK = 32'h00FF_038D;
endpackage : efcc_pkg

// ===== design/efcc_top.sv
// flash command controller: APB register slave with two sequencer cores
// assumes an APB master on pclk; flash array timing is modelled by counters
`timescale 1ns/10ps
//==================================================
// one controller: mode register, command sequencer, status
module efcc_core #(
  parameter int   NV_PRESENT  = 1,
  parameter int   PAGE_W      = 10,
  parameter int   NV_BITS     = 3,
  parameter logic [15:0] ERASE_TICKS = 16'd8,
  parameter logic [15:0] PROG_TICKS  = 16'd8,
  parameter logic [15:0] NV_TICKS    = 16'd4,
  parameter logic [15:0] EALL_TICKS  = 16'd16
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // register strobes
  input  wire logic             mode_wr,
  input  wire logic             cmd_wr,
  input  wire logic [31:0]      wdata,
  input  wire logic [1:0]       err_seen,
  // state
  output efcc_pkg::efcc_mode_s  mode,
  output logic [31:0]           status,
  output logic                  irq,
  output logic [2:0]            read_wait_cycles,
  output logic [2:0]            write_wait_cycles,
  output logic                  security
);
  import efcc_pkg::*;

  efcc_state_e  state;
  efcc_state_e  next_state;
  efcc_code_e   op_code;
  logic [9:0]   op_page;
  logic [15:0]  lock_bits;
  logic [2:0]   nv_bits;
  logic         lock_err;
  logic         cmd_err;
  logic [7:0]   tick_cnt;
  logic [15:0]  op_cnt;

  //==================================================
  // command decode
  efcc_cmd_s  cmd;
  wire        key_ok     = cmd.key == CMD_KEY;
  wire        ready      = state == ST_IDLE;
  wire [3:0]  cmd_region = cmd.page_number[PAGE_W-1 -: 4];
  wire [3:0]  op_region  = op_page[PAGE_W-1 -: 4];
  wire        page_locked = lock_bits[cmd_region];
  logic       code_valid;
  assign cmd = efcc_cmd_s'(wdata);
  always_comb begin
    case (cmd.command_code)
      EFCC_NOP, EFCC_WP, EFCC_SLB, EFCC_WPL, EFCC_CLB,
      EFCC_EA, EFCC_SET_NV_BIT_CMD, EFCC_CLEAR_NV_BIT_CMD, EFCC_SSB: code_valid = 1'b1;
      default: code_valid = 1'b0;
    endcase
  end
  // valid commands written while busy are dropped silently; key or code errors still set the command error flag
  wire accept   = cmd_wr & key_ok & code_valid & ready;
  wire go       = accept & (cmd.command_code != EFCC_NOP);
  wire is_write = (cmd.command_code == EFCC_WP) | (cmd.command_code == EFCC_WPL);
  wire wr_lock_hit = go & is_write & page_locked;
  wire ea_refused  = go & (cmd.command_code == EFCC_EA) & (|lock_bits);
  wire start       = go & ~wr_lock_hit & ~ea_refused;
  wire cmd_err_set = cmd_wr & (~key_ok | ~code_valid);
  wire lock_err_set = wr_lock_hit | ea_refused;

  //==================================================
  // microsecond timebase
  wire tick = tick_cnt >= mode.microsecond_cycles - 8'h01 || mode.microsecond_cycles == 8'h00;
  wire done = tick & (op_cnt == 16'h0000);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 8'h00;
    end else if (ready || tick) begin
      tick_cnt <= 8'h00;
    end else begin
      tick_cnt <= tick_cnt + 8'h01;
    end
  end

  //==================================================
  // sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start) begin
          case (cmd.command_code)
            EFCC_WP, EFCC_WPL: next_state = mode.skip_erase ? ST_PROG : ST_ERASE;
            EFCC_EA:           next_state = ST_EALL;
            default:           next_state = ST_NVOP;
          endcase
        end
      end
      ST_ERASE: if (done) next_state = ST_PROG;
      ST_PROG: begin
        if (done) next_state = (op_code == EFCC_WPL) ? ST_NVOP : ST_IDLE;
      end
      ST_NVOP, ST_EALL: if (done) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  logic [15:0] next_len;
  always_comb begin
    case (next_state)
      ST_ERASE: next_len = ERASE_TICKS;
      ST_PROG:  next_len = PROG_TICKS;
      ST_NVOP:  next_len = NV_TICKS;
      ST_EALL:  next_len = EALL_TICKS;
      default:  next_len = 16'h0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= ST_IDLE;
      op_cnt  <= 16'h0000;
      op_code <= EFCC_NOP;
      op_page <= 10'h000;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        op_cnt <= next_len;
      end else if (tick && op_cnt != 16'h0000) begin
        op_cnt <= op_cnt - 16'h0001;
      end
      if (start) begin
        op_code <= efcc_code_e'(cmd.command_code);
        op_page <= cmd.page_number;
      end
    end
  end

  //==================================================
  // non-volatile state applied at end of its operation
  wire nv_done = (state == ST_NVOP) & done;
  wire [1:0] nv_idx = op_page[1:0];
  wire nv_ok = (NV_PRESENT != 0) && (nv_idx < 2'(NV_BITS));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_bits <= 16'h0000;
      nv_bits   <= 3'h0;
      security  <= 1'b0;
    end else if (nv_done) begin
      case (op_code)
        EFCC_SLB, EFCC_WPL: lock_bits[op_region] <= 1'b1;
        EFCC_CLB:  lock_bits[op_region] <= 1'b0;
        EFCC_SET_NV_BIT_CMD: if (nv_ok) nv_bits[nv_idx] <= 1'b1;
        EFCC_CLEAR_NV_BIT_CMD: if (nv_ok) nv_bits[nv_idx] <= 1'b0;
        EFCC_SSB:  if (NV_PRESENT != 0) security <= 1'b1;
        default: ;
      endcase
    end
  end

  //==================================================
  // error flags: a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_err <= 1'b0;
      cmd_err  <= 1'b0;
    end else begin
      lock_err <= lock_err_set | (lock_err & ~err_seen[0]);
      cmd_err  <= cmd_err_set | (cmd_err & ~err_seen[1]);
    end
  end

  //==================================================
  // mode register and wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode              <= efcc_mode_s'(MODE_RESET);
      read_wait_cycles  <= 3'd1;
      write_wait_cycles <= 3'd2;
    end else begin
      if (mode_wr) mode <= efcc_mode_s'(wdata & MODE_WMASK);
      read_wait_cycles  <= {1'b0, mode.wait_state_count} + 3'd1;
      write_wait_cycles <= (mode.wait_state_count == 2'd3) ? 3'd4
                         : {1'b0, mode.wait_state_count} + 3'd2;
    end
  end

  always_comb begin
    status = 32'h0000_0000;
    status[READY_BIT] = ready;
    status[LOCK_ERROR_FLAG_BIT] = lock_err;
    status[COMMAND_ERROR_FLAG_BIT] = cmd_err;
    status[SECUR_BIT] = security;
    status[NV_LSB +: 3] = nv_bits;
    status[LOCKS_LSB +: 16] = lock_bits;
  end
  assign irq = (ready & mode.ready_ie) | (lock_err & mode.lock_err_ie)
             | (cmd_err & mode.cmd_err_ie);

  //==================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_prog_end;
    state == ST_PROG && done;
  endsequence
  ready_irq_a: assert property (ready && mode.ready_ie |-> irq)
    else $error("ready with enable gives no interrupt");
  err_irq_a: assert property (lock_err_set && mode.lock_err_ie && !mode_wr |=> irq)
    else $error("lock error did not raise interrupt");
  // idle only: an nv phase ending under a busy-time write may move the locks legally
  bad_key_a: assert property (cmd_wr && !key_ok && ready |=> cmd_err && $stable(lock_bits))
    else $error("bad key not flagged or acted on");
  nop_code_a: assert property (accept && !go && !cmd_err |=> !cmd_err && ready)
    else $error("no-op command changed state");
  start_busy_a: assert property (start |=> !ready)
    else $error("accepted command did not clear ready");
  erase_first_a: assert property (start && is_write && !mode.skip_erase
                                  |=> state == ST_ERASE)
    else $error("page not erased before program");
  ea_locked_a: assert property (ea_refused |=> ready && lock_err ##1 ready)
    else $error("erase all ran with a locked region");
  wpl_lock_a: assert property (s_prog_end and op_code == EFCC_WPL
                               |=> state == ST_NVOP)
    else $error("write-and-lock skipped the lock step");
  lock_error_flag_clr_a: assert property (err_seen[0] && !lock_err_set |=> !lock_err)
    else $error("lock error not cleared by read");
  wait_a: assert property (##1 read_wait_cycles == 3'($past(mode.wait_state_count)) + 3'd1)
    else $error("read wait cycles wrong");
endmodule : efcc_core

//==================================================
// top: APB slave decoding two controllers
module efcc_top #(
  parameter logic [15:0] ERASE_TICKS = 16'd8,
  parameter logic [15:0] PROG_TICKS  = 16'd8,
  parameter logic [15:0] NV_TICKS    = 16'd4,
  parameter logic [15:0] EALL_TICKS  = 16'd16
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt and flash side
  output logic             irq,
  output logic [5:0]       read_wait_cycles,
  output logic [5:0]       write_wait_cycles,
  output logic             security
);
  import efcc_pkg::*;

  efcc_mode_s  mode [2];
  logic [31:0] stat [2];
  logic [1:0]  irq_c;
  logic [1:0]  sec_c;

  //==================================================
  // address decode
  wire setup  = psel & ~penable;
  wire access = psel & penable;
  wire [7:0] off0 = {paddr[7:5], 1'b0, paddr[3:0]};
  wire unit   = paddr[4];
  wire hit_mode = off0 == MODE0_OFF;
  wire hit_cmd  = off0 == CMD0_OFF;
  wire hit_stat = off0 == STAT0_OFF;
  wire hit    = hit_mode | hit_cmd | hit_stat;
  wire wr_acc = access & pwrite & hit;
  // flags are cleared only as far as the read actually showed them
  wire [1:0] seen = {prdata[COMMAND_ERROR_FLAG_BIT], prdata[LOCK_ERROR_FLAG_BIT]};
  wire rd_stat = access & ~pwrite & hit_stat;
  assign pready  = 1'b1;
  assign pslverr = access & ~hit;

  // prdata sampled in setup so it is a flop at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= hit_mode ? 32'(mode[unit]) : hit_stat ? stat[unit] : 32'h0000_0000;
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_ctl
    efcc_core #(
      .NV_PRESENT  (i == 0 ? 1 : 0),
      .ERASE_TICKS (ERASE_TICKS),
      .PROG_TICKS  (PROG_TICKS),
      .NV_TICKS    (NV_TICKS),
      .EALL_TICKS  (EALL_TICKS)
    ) u_core (
      .pclk              (pclk),
      .presetn           (presetn),
      .mode_wr           (wr_acc & hit_mode & (unit == 1'(i))),
      .cmd_wr            (wr_acc & hit_cmd & (unit == 1'(i))),
      .wdata             (pwdata),
      .err_seen          (seen & {2{rd_stat & (unit == 1'(i))}}),
      .mode              (mode[i]),
      .status            (stat[i]),
      .irq               (irq_c[i]),
      .read_wait_cycles  (read_wait_cycles[3*i +: 3]),
      .write_wait_cycles (write_wait_cycles[3*i +: 3]),
      .security          (sec_c[i])
    );
  end
  assign irq      = |irq_c;
  assign security = |sec_c;
endmodule : efcc_top

// ===== verif/test_efcc_top.sv
// self-checking bench for the flash command controller register slave
// assumes efcc_pkg is compiled first; bench acts as the APB master
`timescale 1ns/10ps
module test_efcc_top;
  import efcc_pkg::*;
  //==================================================
  // signals and design
  localparam logic [15:0] ERASE_T = 16'h0008;
  localparam logic [15:0] PROG_T  = 16'h0008;
  // 25 MHz: 25 cycles in one microsecond, 38 in 1.5 us rounded up
  localparam logic [31:0] MC_US   = 32'h0019_0000;
  localparam logic [31:0] MC_PROG = 32'h0026_0000;
  localparam int          MC_PROG_N = 38;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [5:0]  read_wait_cycles;
  logic [5:0]  write_wait_cycles;
  logic        security;
  int          bad_count = 0;
  int          tests_run = 0;
  always #20 pclk = ~pclk;
  efcc_top #(.ERASE_TICKS(ERASE_T), .PROG_TICKS(PROG_T), .NV_TICKS(16'h0004),
    .EALL_TICKS(16'h0010)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .read_wait_cycles(read_wait_cycles),
    .write_wait_cycles(write_wait_cycles), .security(security));
  //==================================================
  // shared tasks
  task stop_test;
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) bad_count++;
    r = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    // outputs launched at the access edge are settled by the falling edge
    @(negedge pclk);
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    check(nm, r, exp);
  endtask : rd
  // polls status judging only the ready bit; flags cleared by these reads are lost
  task wait_ready(input logic [7:0] a);
    logic [31:0] r;
    logic e;
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0000_0000, r, e);
      n++;
    end while (r[READY_BIT] !== 1'b1 && n < 500);
    check("ready in time", {31'h0, r[READY_BIT]}, 32'h0000_0001);
  endtask : wait_ready
  // ready enable alone makes irq follow ready, so its low span is the busy time
  task busy_len(input logic [31:0] cmd, output int n);
    n = 0;
    wr(CMD0_OFF, cmd);
    while (irq !== 1'b1 && n < 2000) begin
      @(negedge pclk);
      n++;
    end
  endtask : busy_len
  //==================================================
  // scenarios
  task t_reset;
    logic [31:0] r;
    logic e;
    rd("mode0 reset", MODE0_OFF, MODE_RESET);
    rd("status0 reset", STAT0_OFF, 32'h0000_0001);
    check("rd wait reset", {26'h0, read_wait_cycles}, 32'h0000_0009);
    check("wr wait reset", {26'h0, write_wait_cycles}, 32'h0000_0012);
    apb(1'b0, 8'h6C, 32'h0000_0000, r, e);
    check("unmapped err", {31'h0, e}, 32'h0000_0001);
    wr(MODE0_OFF, 32'hFFFF_FFFF);
    rd("mode0 mask", MODE0_OFF, MODE_WMASK);
    $display("done: reset and access");
  endtask : t_reset
  task t_wait;
    logic [2:0] wexp [4];
    wexp = '{3'h2, 3'h3, 3'h4, 3'h4};
    for (int f = 0; f < 4; f++) begin
      wr(MODE0_OFF, {22'h0, f[1:0], 8'h00});
      @(negedge pclk);
      check("rd wait", {29'h0, read_wait_cycles[2:0]}, f + 1);
      check("wr wait", {29'h0, write_wait_cycles[2:0]}, {29'h0, wexp[f]});
    end
    $display("done: wait states");
  endtask : t_wait
  task t_errors;
    wr(MODE0_OFF, 32'h0000_0008);
    wr(CMD0_OFF, 32'h1200_0001);
    check("irq bad key", {31'h0, irq}, 32'h0000_0001);
    rd("bad key", STAT0_OFF, 32'h0000_0009);
    check("irq cleared", {31'h0, irq}, 32'h0000_0000);
    wr(CMD0_OFF, 32'h5A00_0005);
    rd("reserved", STAT0_OFF, 32'h0000_0009);
    wr(MODE0_OFF, 32'h0000_0000);
    wr(CMD0_OFF, 32'h5A00_0006);
    check("irq masked", {31'h0, irq}, 32'h0000_0000);
    rd("reserved2", STAT0_OFF, 32'h0000_0009);
    wr(CMD0_OFF, 32'h5A00_0000);
    rd("nop", STAT0_OFF, 32'h0000_0001);
    $display("done: key and code errors");
  endtask : t_errors
  task t_locks;
    wr(MODE0_OFF, MC_US | 32'h0000_0004);
    wr(CMD0_OFF, 32'h5A00_4002);
    rd("lock busy", STAT0_OFF, 32'h0000_0000);
    wait_ready(STAT0_OFF);
    rd("locked", STAT0_OFF, 32'h0002_0001);
    wr(CMD0_OFF, 32'h5A00_7F01);
    check("irq lock err", {31'h0, irq}, 32'h0000_0001);
    rd("lock err", STAT0_OFF, 32'h0002_0005);
    rd("lock err clr", STAT0_OFF, 32'h0002_0001);
    wr(CMD0_OFF, 32'h5A00_4008);
    rd("ea refused", STAT0_OFF, 32'h0002_0005);
    wr(CMD0_OFF, 32'h5A00_7004);
    wait_ready(STAT0_OFF);
    rd("unlocked", STAT0_OFF, 32'h0000_0001);
    wr(MODE0_OFF, MC_PROG | 32'h0000_0004);
    wr(CMD0_OFF, 32'h5A00_8003);
    wait_ready(STAT0_OFF);
    rd("wpl locked", STAT0_OFF, 32'h0004_0001);
    wr(MODE0_OFF, MC_US | 32'h0000_0004);
    wr(CMD0_OFF, 32'h5A00_8004);
    wait_ready(STAT0_OFF);
    wr(MODE0_OFF, MC_PROG | 32'h0000_0004);
    wr(CMD0_OFF, 32'h5A00_0008);
    wait_ready(STAT0_OFF);
    rd("ea done", STAT0_OFF, 32'h0000_0001);
    $display("done: lock regions");
  endtask : t_locks
  task t_nv;
    wr(MODE0_OFF, MC_US);
    wr(MODE1_OFF, MC_US);
    wr(CMD0_OFF, 32'h5A00_FD0B);
    wait_ready(STAT0_OFF);
    rd("nv set", STAT0_OFF, 32'h0000_0201);
    wr(CMD0_OFF, 32'h5A00_010D);
    wait_ready(STAT0_OFF);
    rd("nv clr", STAT0_OFF, 32'h0000_0001);
    wr(CMD1_OFF, 32'h5A00_000B);
    wait_ready(STAT1_OFF);
    rd("nv ctl1", STAT1_OFF, 32'h0000_0001);
    wr(CMD0_OFF, 32'h5A00_3F0F);
    wait_ready(STAT0_OFF);
    rd("secure", STAT0_OFF, 32'h0000_0011);
    check("security pin", {31'h0, security}, 32'h0000_0001);
    $display("done: nv and security");
  endtask : t_nv
  task t_prog;
    int a;
    int b;
    wr(MODE0_OFF, MC_PROG);
    check("irq no ie", {31'h0, irq}, 32'h0000_0000);
    wr(MODE0_OFF, MC_PROG | 32'h0000_0001);
    check("irq ready", {31'h0, irq}, 32'h0000_0001);
    busy_len(32'h5A00_0001, a);
    wr(MODE0_OFF, MC_PROG | 32'h0000_0081);
    busy_len(32'h5A00_0001, b);
    check("erase span", a - b, ({16'h0, ERASE_T} + 1) * MC_PROG_N);
    check("prog span", b, ({16'h0, PROG_T} + 1) * MC_PROG_N);
    $display("done: program timing");
  endtask : t_prog
  //==================================================
  // main sequence and watchdog
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_wait;
    t_errors;
    t_locks;
    t_nv;
    t_prog;
    stop_test;
  end
  initial begin
    repeat (40000) @(posedge pclk);
    bad_count++;
    stop_test;
  end
endmodule : test_efcc_top
